// [rtl/fcto_chan.sv]
// One temperature channel: applies the signed reading offset and turns
// the adjusted reading into a fan demand level from start and span.
// Assumes readings are whole degrees, two's complement, on clk_i's domain.
`timescale 1ns/100ps
`include "fcto_params.svh"

module fcto_chan
(
	input wire logic [7:0] reading_i,
	input wire logic [7:0] offset_i,
	input wire logic [7:0] start_span_i,
	output fcto_pkg::fcto_chan_type chan_o
);

	logic signed [9:0] sum;
	logic signed [9:0] delta;
	logic [9:0] scaled;
	logic [2:0] span;
	logic [7:0] adj;

	always_comb
	begin
		if (offset_i[`FCTO_SIGN_BIT])
		begin
			sum = $signed({{2{reading_i[7]}}, reading_i}) -
				$signed({6'h00, offset_i[`FCTO_MAG_MSB:`FCTO_MAG_LSB]}); // RULE9 RULE11 RULE12
		end
		else
		begin
			sum = $signed({{2{reading_i[7]}}, reading_i}) +
				$signed({6'h00, offset_i[`FCTO_MAG_MSB:`FCTO_MAG_LSB]}); // RULE10
		end
		// Saturate rather than wrap near the ends of the range
		if (sum > `FCTO_TEMP_MAX)
		begin
			adj = 8'h7F;
		end
		else if (sum < `FCTO_TEMP_MIN)
		begin
			adj = 8'h80;
		end
		else
		begin
			adj = sum[7:0];
		end
		// Start code counts 4 degree steps
		delta = $signed({{2{adj[7]}}, adj}) -
			$signed({3'h0, start_span_i[`FCTO_START_MSB:`FCTO_START_LSB], 2'h0}); // RULE1
		// Undefined span codes act as the widest span
		if (start_span_i[`FCTO_SPAN_MSB:`FCTO_SPAN_LSB] > `FCTO_SPAN_MAX_CODE)
		begin
			span = `FCTO_SPAN_MAX_CODE;
		end
		else
		begin
			span = start_span_i[`FCTO_SPAN_MSB:`FCTO_SPAN_LSB]; // RULE5
		end
		// Span is 5 << code, so 15 * delta / span is (3 * delta) >> code
		if (delta <= 10'sh000)
		begin
			scaled = 10'h000;
		end
		else
		begin
			scaled = 10'((10'(delta) * `FCTO_SPAN_SCALE) >> span); // RULE19
		end
		chan_o.adj = adj;
		if (scaled > 10'({6'h00, `FCTO_FULL_SPEED}))
		begin
			chan_o.level = `FCTO_FULL_SPEED;
		end
		else
		begin
			chan_o.level = scaled[3:0];
		end
	end

endmodule

// [rtl/fcto_params.svh]
// Offsets, field positions, reset values and fixed figures of the fan
// control threshold and offset register bank. Definitions only.
`ifndef FCTO_PARAMS_SVH
`define FCTO_PARAMS_SVH

// Register offsets on the management bus register port
`define FCTO_ADDR_LOCAL_OFS 8'h0D
`define FCTO_ADDR_REM1_OFS 8'h0E
`define FCTO_ADDR_REM2_OFS 8'h0F
`define FCTO_ADDR_MIN_SPEED 8'h20
`define FCTO_ADDR_FILTER 8'h23
`define FCTO_ADDR_LOCAL_SS 8'h24
`define FCTO_ADDR_REM1_SS 8'h25
`define FCTO_ADDR_REM2_SS 8'h26
`define FCTO_ADDR_OVT 8'h3F

// Power-on values
`define FCTO_RST_OFS 8'h00
`define FCTO_RST_FILTER 8'h50
`define FCTO_RST_LOCAL_SS 8'h41
`define FCTO_RST_REM_SS 8'h61
`define FCTO_RST_MIN_SPEED 8'h55
`define FCTO_RST_OVT_EN 1'h1
// Revision nibble: arbitrary neutral value
`define FCTO_REVISION 4'h1

// Field positions
`define FCTO_START_MSB 7
`define FCTO_START_LSB 3
`define FCTO_SPAN_MSB 2
`define FCTO_SPAN_LSB 0
`define FCTO_SIGN_BIT 7
`define FCTO_MAG_MSB 3
`define FCTO_MAG_LSB 0
`define FCTO_OVT_EN_BIT 7
`define FCTO_REV_MSB 3
`define FCTO_REV_LSB 0
`define FCTO_MINSPD1_MSB 3
`define FCTO_MINSPD1_LSB 0
`define FCTO_MINSPD2_MSB 7
`define FCTO_MINSPD2_LSB 4

// Fixed figures of the control law
`define FCTO_SPAN_MAX_CODE 3'h4
`define FCTO_SPAN_SCALE 10'h003
`define FCTO_FULL_SPEED 4'hF
`define FCTO_TEMP_MAX 10'sh07F
`define FCTO_TEMP_MIN -10'sh080

`endif

// [rtl/fcto_pkg.sv]
// Types shared by the register bank and its per-channel datapath.
package fcto_pkg;

	typedef struct packed
	{
		logic [2:0][7:0] offset;
		logic [2:0][7:0] start_span;
		logic [7:0] filter;
		logic [7:0] min_speed;
		logic ovt_en;
	} fcto_reg_type;

	typedef struct packed
	{
		logic [7:0] adj;
		logic [3:0] level;
	} fcto_chan_type;

	typedef struct packed
	{
		fcto_reg_type regs;
		logic [1:0] ovt_sync;
		logic [7:0] rd_data;
		logic [2:0][7:0] adj;
		logic [1:0][3:0] duty;
		logic full_speed;
	} fcto_state_type;

endpackage

// [rtl/fcto_regs.sv]
// Fan control threshold and offset register bank with its automatic
// speed law. Assumes the management bus slave logic on clk_i presents
// decoded register accesses; readings come from the measurement engine.
//
// Notes on behaviour
// RULE1: Start temperature, bits 7:3, 4 degree steps.
// RULE2: Separate start and span per channel.
// RULE3: Local start resets to 32 degrees.
// RULE4: Remote starts reset to 48 degrees.
// RULE5: Span bits 2:0, 5 to 80 degrees.
// RULE6: Enable set: low overtemp pin forces full.
// RULE7: Enable clear: overtemp pin forces nothing.
// RULE8: Read-only revision nibble, writes ignored.
// RULE9: Local sign bit selects add or subtract.
// RULE10: Offset magnitude bits 3:0, up to 15.
// RULE11: Remote 1 sign selects add or subtract.
// RULE12: Remote 2 sign selects add or subtract.
// RULE13: Remote offset bits 6:4 read zero.
// RULE14: Offset registers reset to zero.
// RULE15: Local start and span reset 41H.
// RULE16: Fan filter register at 23H, reset 50H.
// RULE17: Overtemp behaviour register at 3FH, reset 80H; the revision nibble of 1 makes it read 81H.
// RULE18: Minimum speed nibble floors automatic fan speed.
// RULE19: Ramp from minimum to full across span; code ramps from zero at start, floored by the minimum.
`timescale 1ns/100ps
`include "fcto_params.svh"

module fcto_regs
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic overtemp_n_i,
	input wire logic [7:0] local_reading_i,
	input wire logic [7:0] remote1_reading_i,
	input wire logic [7:0] remote2_reading_i,
	output logic [7:0] reg_rdata_o,
	output logic [7:0] local_adjusted_o,
	output logic [7:0] remote1_adjusted_o,
	output logic [7:0] remote2_adjusted_o,
	output logic [3:0] fan1_duty_o,
	output logic [3:0] fan2_duty_o,
	output logic fan_full_speed_o,
	output logic [7:0] fan_filter_config_o
);

	////////////////////////////////////////////////////////////////////////////
	// Register select, one bit per mapped offset

	localparam int SEL_LOCAL_OFS = 0;
	localparam int SEL_REM1_OFS = 1;
	localparam int SEL_REM2_OFS = 2;
	localparam int SEL_MIN_SPEED = 3;
	localparam int SEL_FILTER = 4;
	localparam int SEL_LOCAL_SS = 5;
	localparam int SEL_REM1_SS = 6;
	localparam int SEL_REM2_SS = 7;
	localparam int SEL_OVT = 8;

	// Shared by the read and write paths so both always agree on the map
	function automatic logic [8:0] reg_select
	(
		input logic [7:0] addr
	);
		logic [8:0] sel;
		sel = 9'h000;
		if (addr == `FCTO_ADDR_LOCAL_OFS)
		begin
			sel[SEL_LOCAL_OFS] = 1'h1;
		end
		else if (addr == `FCTO_ADDR_REM1_OFS)
		begin
			sel[SEL_REM1_OFS] = 1'h1;
		end
		else if (addr == `FCTO_ADDR_REM2_OFS)
		begin
			sel[SEL_REM2_OFS] = 1'h1;
		end
		else if (addr == `FCTO_ADDR_MIN_SPEED)
		begin
			sel[SEL_MIN_SPEED] = 1'h1;
		end
		else if (addr == `FCTO_ADDR_FILTER)
		begin
			sel[SEL_FILTER] = 1'h1;
		end
		else if (addr == `FCTO_ADDR_LOCAL_SS)
		begin
			sel[SEL_LOCAL_SS] = 1'h1;
		end
		else if (addr == `FCTO_ADDR_REM1_SS)
		begin
			sel[SEL_REM1_SS] = 1'h1;
		end
		else if (addr == `FCTO_ADDR_REM2_SS)
		begin
			sel[SEL_REM2_SS] = 1'h1;
		end
		else if (addr == `FCTO_ADDR_OVT)
		begin
			sel[SEL_OVT] = 1'h1;
		end
		else
		begin
			// Unmapped offsets select nothing
			sel = 9'h000;
		end
		return sel;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register read decode

	function automatic logic [7:0] read_reg
	(
		input logic [7:0] addr,
		input fcto_pkg::fcto_reg_type regs
	);
		logic [8:0] sel;
		logic [7:0] data;
		data = 8'h00;
		sel = reg_select(addr);
		if (sel[SEL_LOCAL_OFS])
		begin
			data[`FCTO_SIGN_BIT] = regs.offset[0][`FCTO_SIGN_BIT];
			data[`FCTO_MAG_MSB:`FCTO_MAG_LSB] = regs.offset[0][`FCTO_MAG_MSB:`FCTO_MAG_LSB];
		end
		else if (sel[SEL_REM1_OFS])
		begin
			data[`FCTO_SIGN_BIT] = regs.offset[1][`FCTO_SIGN_BIT];
			data[`FCTO_MAG_MSB:`FCTO_MAG_LSB] = regs.offset[1][`FCTO_MAG_MSB:`FCTO_MAG_LSB]; // RULE13
		end
		else if (sel[SEL_REM2_OFS])
		begin
			data[`FCTO_SIGN_BIT] = regs.offset[2][`FCTO_SIGN_BIT];
			data[`FCTO_MAG_MSB:`FCTO_MAG_LSB] = regs.offset[2][`FCTO_MAG_MSB:`FCTO_MAG_LSB]; // RULE13
		end
		else if (sel[SEL_MIN_SPEED])
		begin
			data = regs.min_speed;
		end
		else if (sel[SEL_FILTER])
		begin
			data = regs.filter; // RULE16
		end
		else if (sel[SEL_LOCAL_SS])
		begin
			data = regs.start_span[0];
		end
		else if (sel[SEL_REM1_SS])
		begin
			data = regs.start_span[1];
		end
		else if (sel[SEL_REM2_SS])
		begin
			data = regs.start_span[2];
		end
		else if (sel[SEL_OVT])
		begin
			data[`FCTO_OVT_EN_BIT] = regs.ovt_en; // RULE17
			data[`FCTO_REV_MSB:`FCTO_REV_LSB] = `FCTO_REVISION; // RULE8
		end
		else
		begin
			// Unmapped offsets read as zero
			data = 8'h00;
		end
		return data;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Higher of two speed codes

	function automatic logic [3:0] max_speed
	(
		input logic [3:0] a,
		input logic [3:0] b
	);
		logic [3:0] m;
		m = a;
		if (b > a)
		begin
			m = b;
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	fcto_pkg::fcto_state_type st;
	fcto_pkg::fcto_state_type next_st;
	fcto_pkg::fcto_chan_type [2:0] chan;
	logic [2:0][7:0] reading;

	assign reading[0] = local_reading_i;
	assign reading[1] = remote1_reading_i;
	assign reading[2] = remote2_reading_i;

	////////////////////////////////////////////////////////////////////////////
	// Per-channel offset and demand

	generate
		for (genvar c = 0; c < 3; c++)
		begin : g_chan
			fcto_chan u_chan
			(
				.reading_i(reading[c]),
				.offset_i(st.regs.offset[c]),
				.start_span_i(st.regs.start_span[c]), // RULE2
				.chan_o(chan[c])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		logic [3:0] demand;
		logic forced;
		logic [8:0] wr_sel;
		demand = 4'h0;
		forced = 1'b0;
		wr_sel = reg_select(reg_addr_i);
		next_st = st;

		// Overtemp pin comes from outside: two flops before use
		next_st.ovt_sync = {st.ovt_sync[0], overtemp_n_i};

		// Register writes; bits with no storage are simply dropped
		if (reg_wr_i)
		begin
			if (wr_sel[SEL_LOCAL_OFS])
			begin
				next_st.regs.offset[0] = reg_wdata_i;
			end
			else if (wr_sel[SEL_REM1_OFS])
			begin
				next_st.regs.offset[1] = reg_wdata_i;
			end
			else if (wr_sel[SEL_REM2_OFS])
			begin
				next_st.regs.offset[2] = reg_wdata_i;
			end
			else if (wr_sel[SEL_MIN_SPEED])
			begin
				next_st.regs.min_speed = reg_wdata_i;
			end
			else if (wr_sel[SEL_FILTER])
			begin
				next_st.regs.filter = reg_wdata_i; // RULE16
			end
			else if (wr_sel[SEL_LOCAL_SS])
			begin
				next_st.regs.start_span[0] = reg_wdata_i; // RULE1
			end
			else if (wr_sel[SEL_REM1_SS])
			begin
				next_st.regs.start_span[1] = reg_wdata_i;
			end
			else if (wr_sel[SEL_REM2_SS])
			begin
				next_st.regs.start_span[2] = reg_wdata_i;
			end
			else if (wr_sel[SEL_OVT])
			begin
				// Only the enable is writable; revision is a constant
				next_st.regs.ovt_en = reg_wdata_i[`FCTO_OVT_EN_BIT]; // RULE8
			end
		end

		// Read data reflects the register state before this cycle's write
		next_st.rd_data = read_reg(reg_addr_i, st.regs);

		// Adjusted readings
		for (int c = 0; c < 3; c++)
		begin
			next_st.adj[c] = chan[c].adj; // RULE9 RULE11 RULE12
		end

		// Channel with the highest demand level sets the shared demand
		demand = max_speed(max_speed(chan[0].level, chan[1].level), chan[2].level);

		// Full speed only when enabled and the pin is low
		forced = st.regs.ovt_en & ~st.ovt_sync[1]; // RULE6 RULE7
		next_st.full_speed = forced;

		if (forced)
		begin
			next_st.duty[0] = `FCTO_FULL_SPEED; // RULE6
			next_st.duty[1] = `FCTO_FULL_SPEED;
		end
		else
		begin
			next_st.duty[0] = max_speed(demand,
				st.regs.min_speed[`FCTO_MINSPD1_MSB:`FCTO_MINSPD1_LSB]); // RULE18 RULE19
			next_st.duty[1] = max_speed(demand,
				st.regs.min_speed[`FCTO_MINSPD2_MSB:`FCTO_MINSPD2_LSB]); // RULE18
		end

		// Power-on values
		if (sys_rst_i)
		begin
			next_st.regs.offset[0] = `FCTO_RST_OFS; // RULE14
			next_st.regs.offset[1] = `FCTO_RST_OFS;
			next_st.regs.offset[2] = `FCTO_RST_OFS;
			next_st.regs.start_span[0] = `FCTO_RST_LOCAL_SS; // RULE3 RULE15
			next_st.regs.start_span[1] = `FCTO_RST_REM_SS; // RULE4
			next_st.regs.start_span[2] = `FCTO_RST_REM_SS; // RULE4
			next_st.regs.filter = `FCTO_RST_FILTER;
			next_st.regs.min_speed = `FCTO_RST_MIN_SPEED;
			next_st.regs.ovt_en = `FCTO_RST_OVT_EN; // RULE17
			// Pin idles high; avoids a false full-speed burst after reset
			next_st.ovt_sync = 2'h3;
			next_st.rd_data = 8'h00;
			next_st.adj = '0;
			next_st.duty = '0;
			next_st.full_speed = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_i)
	begin
		st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register

	assign reg_rdata_o = st.rd_data;
	assign local_adjusted_o = st.adj[0];
	assign remote1_adjusted_o = st.adj[1];
	assign remote2_adjusted_o = st.adj[2];
	assign fan1_duty_o = st.duty[0];
	assign fan2_duty_o = st.duty[1];
	assign fan_full_speed_o = st.full_speed;
	assign fan_filter_config_o = st.regs.filter;

endmodule

// [rtl/fcto_regs_unused_guard.sv]
// Holds no logic: the bank needs no extra stage between its flops and pins.
// Assumes nothing of its surroundings.

// [testbench/fcto_host_model.sv]
// Host model on the register port: single-byte writes and reads.
// Assumes one clock; requests change 1 ns after the rising edge.
`timescale 1ns/100ps
module fcto_host_model
(
	input wire logic clk_i,
	input wire logic [7:0] reg_rdata_i,
	output logic [7:0] reg_addr_o = 8'h00,
	output logic reg_wr_o = 1'b0,
	output logic [7:0] reg_wdata_o = 8'h00
);
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		reg_addr_o = a;
		reg_wr_o = 1'b1;
		reg_wdata_o = d;
		@(posedge clk_i);
		#1;
		reg_wr_o = 1'b0;
		// Inverted so a stale byte never passes for written data
		reg_wdata_o = ~d;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1;
		reg_addr_o = a;
		@(posedge clk_i);
		#1;
		d = reg_rdata_i;
	endtask
endmodule

// [testbench/fcto_regs_bench.sv]
// Self-checking bench for the threshold and offset register bank.
// Assumes the host model on the register port and the bound checker.
`timescale 1ns/100ps
`include "fcto_params.svh"
module fcto_regs_bench;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic overtemp_n = 1'b1;
	logic [2:0][7:0] rd = '0;
	wire logic [2:0][7:0] adj;
	wire logic [7:0] addr, wdata, rdata, filt;
	wire logic wr, full;
	wire logic [3:0] d1, d2;
	logic [7:0] v;
	int err_total = 0;
	int compares = 0;
	int cyc = 0;

	fcto_host_model u_fcto_host_model(.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wr_o(wr),
		.reg_wdata_o(wdata));
	fcto_regs u_fcto_regs(.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_wdata_i(wdata), .overtemp_n_i(overtemp_n), .local_reading_i(rd[0]), .remote1_reading_i(rd[1]),
		.remote2_reading_i(rd[2]), .reg_rdata_o(rdata), .local_adjusted_o(adj[0]), .remote1_adjusted_o(adj[1]),
		.remote2_adjusted_o(adj[2]), .fan1_duty_o(d1), .fan2_duty_o(d2), .fan_full_speed_o(full),
		.fan_filter_config_o(filt));

	////////////////////////////////////////////////////////////
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task w(input logic [7:0] a, input logic [7:0] d);
		u_fcto_host_model.wr(a, d);
	endtask
	task rc(input logic [7:0] a, input logic [7:0] e);
		u_fcto_host_model.rd(a, v);
		chk(v, e);
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	////////////////////////////////////////////////////////////
	task t_reset;
		logic [7:0] a [8];
		logic [7:0] e [8];
		a = '{8'h0D, 8'h0E, 8'h0F, 8'h23, 8'h24, 8'h25, 8'h26, 8'h3F};
		e = '{8'h00, 8'h00, 8'h00, 8'h50, 8'h41, 8'h61, 8'h61, {4'h8, `FCTO_REVISION}};
		for (int i = 0; i < 8; i++)
			rc(a[i], e[i]);
		chk(filt, 8'h50);
		$display("reset end");
	endtask
	task t_ramp;
		logic [7:0] r [3];
		logic [3:0] e [3];
		r = '{8'h14, 8'h24, 8'h2A};
		e = '{4'h5, 4'h6, 4'hF};
		for (int i = 0; i < 3; i++)
		begin
			rd[0] = r[i];
			wt(3);
			chk({4'h0, d1}, {4'h0, e[i]});
			chk({4'h0, d2}, {4'h0, e[i]});
		end
		$display("ramp end");
	endtask
	task t_ovt;
		rd[0] = 8'h14;
		overtemp_n = 1'b0;
		wt(4);
		chk({7'h0, full}, 8'h01);
		chk({4'h0, d1}, 8'h0F);
		w(8'h3F, 8'h00);
		wt(4);
		chk({7'h0, full}, 8'h00);
		chk({4'h0, d2}, 8'h05);
		overtemp_n = 1'b1;
		$display("overtemp end");
	endtask
	task t_rev;
		w(8'h3F, 8'h7E);
		rc(8'h3F, {4'h0, `FCTO_REVISION});
		w(8'h3F, 8'hFF);
		rc(8'h3F, {4'h8, `FCTO_REVISION});
		$display("revision end");
	endtask
	task t_pad;
		w(8'h0E, 8'hF7);
		rc(8'h0E, 8'h87);
		w(8'h0F, 8'h75);
		rc(8'h0F, 8'h05);
		$display("pad end");
	endtask
	task t_ofs;
		for (int c = 0; c < 3; c++)
		begin
			rd[c] = 8'h32;
			w(8'h0D + 8'(c), 8'h0F);
			wt(3);
			chk(adj[c], 8'h41);
			w(8'h0D + 8'(c), 8'h8F);
			wt(3);
			chk(adj[c], 8'h23);
			w(8'h0D + 8'(c), 8'h00);
			rd[c] = 8'h00;
		end
		$display("offset end");
	endtask
	task t_rw;
		for (int s = 0; s < 5; s++)
		begin
			for (int c = 0; c < 3; c++)
				w(8'h24 + 8'(c), {5'h1F - 5'(c), 3'(s)});
			for (int c = 0; c < 3; c++)
				rc(8'h24 + 8'(c), {5'h1F - 5'(c), 3'(s)});
		end
		w(8'h23, 8'hA6);
		rc(8'h23, 8'hA6);
		chk(filt, 8'hA6);
		w(8'h24, 8'h40);
		rd[0] = 8'h22;
		wt(3);
		chk({4'h0, d1}, 8'h06);
		w(8'h25, 8'h41);
		rd[0] = 8'h00;
		rd[1] = 8'h24;
		wt(3);
		chk({4'h0, d2}, 8'h06);
		w(8'h20, 8'h93);
		rc(8'h20, 8'h93);
		chk({4'h0, d1}, 8'h06);
		chk({4'h0, d2}, 8'h09);
		$display("rw end");
	endtask

	////////////////////////////////////////////////////////////
	initial
	begin
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			err_total++;
			end_of_test;
		end
	end
	initial
	begin
		repeat (4) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		t_reset;
		t_ramp;
		t_ovt;
		t_rev;
		t_pad;
		t_ofs;
		t_rw;
		end_of_test;
	end
endmodule

// [testbench/fcto_regs_checker.sv]
// Checker for the threshold and offset register bank.
// Assumes the offsets and revision nibble of the params header.
`timescale 1ns/100ps
`include "fcto_params.svh"
module fcto_regs_checker
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic overtemp_n_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [3:0] fan1_duty_o,
	input wire logic [3:0] fan2_duty_o,
	input wire logic fan_full_speed_o,
	input wire logic [7:0] fan_filter_config_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	logic ovt_en;
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			ovt_en <= 1'b1;
		else if (reg_wr_i && reg_addr_i == `FCTO_ADDR_OVT)
			ovt_en <= reg_wdata_i[7];
	end
	////////////////////////////////////////////////////////////
	rev_read_only_a:
		assert property (!$past(sys_rst_i, 2) && $past(reg_addr_i) == 8'h3F |-> reg_rdata_o[6:0] == {3'h0, `FCTO_REVISION})
		else $error("revision byte wrong");
	pad_zero_a:
		assert property (!$past(sys_rst_i, 2) && $past(reg_addr_i) inside {[8'h0E:8'h0F]} |-> reg_rdata_o[6:4] == 3'h0)
		else $error("offset pad bits not zero");
	ovt_force_a:
		assert property ((!overtemp_n_i && ovt_en) [*3] |=> fan_full_speed_o)
		else $error("overtemp did not force full speed");
	ovt_quiet_a:
		assert property (!ovt_en |=> !fan_full_speed_o)
		else $error("full speed forced while disabled");
	ovt_release_a:
		assert property (overtemp_n_i [*3] |=> !fan_full_speed_o)
		else $error("full speed held with pin high");
	full_duty_a:
		assert property (fan_full_speed_o |-> fan1_duty_o == 4'hF && fan2_duty_o == 4'hF)
		else $error("forced duty not full");
	wr_back_a:
		assert property (reg_wr_i && reg_addr_i inside {[8'h23:8'h26]} ##1 !reg_wr_i && $stable(reg_addr_i)
			|=> reg_rdata_o == $past(reg_wdata_i, 2))
		else $error("write not read back");
	en_back_a:
		assert property (reg_wr_i && reg_addr_i == 8'h3F ##1 !reg_wr_i && $stable(reg_addr_i)
			|=> reg_rdata_o[7] == $past(reg_wdata_i[7], 2))
		else $error("enable bit not read back");
	filt_hold_a:
		assert property (!(reg_wr_i && reg_addr_i == 8'h23) [*2] |=> $stable(fan_filter_config_o))
		else $error("filter output moved without write");
	cover property (!overtemp_n_i && ovt_en ##3 fan_full_speed_o);
	cover property (reg_wr_i && reg_addr_i == 8'h3F && !reg_wdata_i[7]);
	cover property (reg_wr_i && reg_addr_i inside {[8'h0D:8'h0F]} && reg_wdata_i[7]);
endmodule
bind fcto_regs fcto_regs_checker u_fcto_regs_checker(.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .overtemp_n_i(overtemp_n_i),
	.reg_rdata_o(reg_rdata_o), .fan1_duty_o(fan1_duty_o), .fan2_duty_o(fan2_duty_o),
	.fan_full_speed_o(fan_full_speed_o), .fan_filter_config_o(fan_filter_config_o));
